// ===== hw/dtspwm_pkg.sv
// Purpose: shared constants and types of the dual timer with split mode and pwm
// Assumes: 8-bit register port, one 25 MHz clock
// Notes: register offsets are byte addresses on the plain register port
package dtspwm_pkg;

  // register offsets
  localparam logic [7:0] OFS_CTRL_FLAGS = 8'h88;
  localparam logic [7:0] OFS_MODE_SEL = 8'h89;
  localparam logic [7:0] OFS_A_COUNT_LOW = 8'h8a;
  localparam logic [7:0] OFS_B_COUNT_LOW = 8'h8b;
  localparam logic [7:0] OFS_A_COUNT_HIGH = 8'h8c;
  localparam logic [7:0] OFS_B_COUNT_HIGH = 8'h8d;
  localparam logic [7:0] OFS_PRESCALE_PWM = 8'h91;
  localparam logic [7:0] OFS_A_RELOAD_LOW = 8'h92;
  localparam logic [7:0] OFS_B_RELOAD_LOW = 8'h93;
  localparam logic [7:0] OFS_A_RELOAD_HIGH = 8'h94;
  localparam logic [7:0] OFS_B_RELOAD_HIGH = 8'h95;

  // control and flag register bits
  localparam int BIT_OVF_B = 7;
  localparam int BIT_RUN_B = 6;
  localparam int BIT_OVF_A = 5;
  localparam int BIT_RUN_A = 4;
  localparam int BIT_EIRQ_FLAG_B = 3;
  localparam int BIT_EIRQ_TYPE_B = 2;
  localparam int BIT_EIRQ_FLAG_A = 1;
  localparam int BIT_EIRQ_TYPE_A = 0;

  // mode register: one nibble per timer
  localparam int NIB_A = 0;
  localparam int NIB_B = 4;
  localparam int POS_MODE = 0;
  localparam int POS_CNT_SEL = 2;
  localparam int POS_GATE = 3;

  // prescale and pwm register fields
  localparam int POS_PSC_A = 0;
  localparam int POS_PSC_B = 3;
  localparam int BIT_PWM_EN_A = 6;
  localparam int BIT_PWM_EN_B = 7;

  // operating modes
  localparam logic [1:0] MODE_VAR = 2'h0;
  localparam logic [1:0] MODE_AR16 = 2'h1;
  localparam logic [1:0] MODE_AR8 = 2'h2;
  localparam logic [1:0] MODE_SPLIT = 2'h3;

  // reset values
  localparam logic [7:0] RST_CTRL_FLAGS = 8'h00;
  localparam logic [7:0] RST_MODE_SEL = 8'h00;
  localparam logic [7:0] RST_PRESCALE_PWM = 8'h24;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [3:0] RST_PIN_IDLE = 4'hf;

  // pin vector positions in the synchroniser
  localparam int PIN_TMR_A = 0;
  localparam int PIN_TMR_B = 1;
  localparam int PIN_EIRQ_A = 2;
  localparam int PIN_EIRQ_B = 3;

  // result of one counting step of a timer
  typedef struct packed {
    logic [7:0] low;
    logic [7:0] high;
    logic high_wrap;
    logic ovf;
  } dtspwm_step_t;

endpackage

// ===== hw/dtspwm_pinsync.sv
// Purpose: two-flop synchroniser and falling edge detect for the four pins
// Assumes: pins are asynchronous to clk_i
// Notes: reset to high so an idle-high pin gives no false edge
module dtspwm_pinsync (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic [3:0] pin_i,
  output logic [3:0] level_o,
  output logic [3:0] fall_o
);

  typedef struct packed {
    logic [3:0] meta;
    logic [3:0] sync;
    logic [3:0] prev;
  } dtspwm_sync_t;

  dtspwm_sync_t st_ff;
  dtspwm_sync_t nxt_st;

  // first stage only feeds the second stage
  always_comb begin
    nxt_st.meta = pin_i;
    nxt_st.sync = st_ff.meta;
    nxt_st.prev = st_ff.sync;
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      st_ff <= {dtspwm_pkg::RST_PIN_IDLE, dtspwm_pkg::RST_PIN_IDLE, dtspwm_pkg::RST_PIN_IDLE};
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign level_o = st_ff.sync;
  // high in one sample, low in the next
  assign fall_o = st_ff.prev & ~st_ff.sync;

endmodule

// ===== hw/dtspwm_extirq.sv
// Purpose: external interrupt request flags for both interrupt pins
// Assumes: level and edge inputs come from the pin synchroniser
// Notes: index 0 is pin a, index 1 is pin b
module dtspwm_extirq (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic [1:0] type_i,
  input wire logic [1:0] level_i,
  input wire logic [1:0] fall_i,
  input wire logic [1:0] ack_i,
  input wire logic wr_i,
  input wire logic [1:0] wdata_i,
  output logic [1:0] flag_o
);

  typedef struct packed {
    logic [1:0] flag;
  } dtspwm_eirq_t;

  dtspwm_eirq_t st_ff;
  dtspwm_eirq_t nxt_st;

  // a falling edge wins over a vector ack or a write in the same cycle
  always_comb begin
    nxt_st = st_ff;
    for (int i = 0; i < 2; i++) begin
      if (!type_i[i]) begin
        nxt_st.flag[i] = ~level_i[i];
      end else if (fall_i[i]) begin
        nxt_st.flag[i] = 1'b1;
      end else if (ack_i[i]) begin
        nxt_st.flag[i] = 1'b0;
      end else if (wr_i) begin
        nxt_st.flag[i] = wdata_i[i];
      end
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign flag_o = st_ff.flag;

endmodule

// ===== hw/dtspwm_top.sv
// Purpose: two timer/counters with variable, auto-reload, split and pwm modes
// Assumes: cpu reaches registers over a plain strobe port, reads answer one cycle later
// Notes: timer pins and interrupt pins are asynchronous and pass two flops first

// Behaviour
// - timer b in mode 3 holds count
// - split mode: a low byte own counter
// - split: a high byte clocks, b run/flag
// - split: b runs unless mode 3, no flag
// - overflow flags set by hw, cleared on vector
// - edge type: falling edge sets irq flag
// - level type: flag follows inverted pin
// - type bit one edge, zero level
// - gate bit requires irq pin high
// - select bit: clock or timer pin events
// - mode 0 prescaled, mode 1 16-bit reload
// - mode 2 low byte reloads from high
// - prescale field plus one active bits
// - pwm enables drive the timer pins
// - pwm: high byte compared to high reload
// - pwm high at 00, low at compare
// - pwm on: compare updates only on high byte wrap
// - compare 00 keeps output low
// - pwm only in mode 0 or 1
// - pwm mode 1: low byte reloads linearly
// - timer function counts every clock
// - counter counts sampled falling pin edges
// - mode 1 rolls over, reloads, sets flag
// - mode 2 overflow sets flag, reloads low
module dtspwm_top (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  input wire logic timer_pin_a_i,
  input wire logic timer_pin_b_i,
  input wire logic ext_irq_pin_a_i,
  input wire logic ext_irq_pin_b_i,
  input wire logic vector_ack_ovf_a_i,
  input wire logic vector_ack_ovf_b_i,
  input wire logic vector_ack_eirq_a_i,
  input wire logic vector_ack_eirq_b_i,
  output logic overflow_flag_a_o,
  output logic overflow_flag_b_o,
  output logic ext_irq_flag_a_o,
  output logic ext_irq_flag_b_o,
  output logic baud_tick_b_o,
  output logic timer_pin_a_o,
  output logic timer_pin_a_oe_o,
  output logic timer_pin_b_o,
  output logic timer_pin_b_oe_o
);

  typedef struct packed {
    logic overflow_flag_a;
    logic overflow_flag_b;
    logic run_bit_a;
    logic run_bit_b;
    logic ext_irq_type_a;
    logic ext_irq_type_b;
    logic [7:0] mode_sel;
    logic [7:0] prescale_pwm;
    logic [7:0] low_count_a;
    logic [7:0] high_count_a;
    logic [7:0] low_count_b;
    logic [7:0] high_count_b;
    logic [7:0] low_reload_a;
    logic [7:0] high_reload_a;
    logic [7:0] low_reload_b;
    logic [7:0] high_reload_b;
    logic [7:0] cmp_a;
    logic [7:0] cmp_b;
    logic pwm_a;
    logic pwm_b;
    logic baud_b;
    logic [7:0] rdata;
  } dtspwm_state_t;

  dtspwm_state_t st_ff;
  dtspwm_state_t nxt_st;

  logic [3:0] pin_level;
  logic [3:0] pin_fall;
  logic [1:0] eirq_flag;
  logic [1:0] mode_a;
  logic [1:0] mode_b;
  logic split;
  logic pwm_act_a;
  logic pwm_act_b;
  logic tick_a;
  logic tick_b;
  logic tick_split_high;
  logic run_eff_b;
  logic ctrl_wr;
  dtspwm_pkg::dtspwm_step_t step_a;
  dtspwm_pkg::dtspwm_step_t step_b;

  // one counting step of a timer in modes 0, 1, 2; mode 3 steps the low byte only
  function automatic dtspwm_pkg::dtspwm_step_t timer_step(
    input logic [1:0] mode,
    input logic [2:0] psc,
    input logic pwm,
    input logic tick,
    input logic [7:0] low,
    input logic [7:0] high,
    input logic [7:0] rl,
    input logic [7:0] rh
  );
    logic [7:0] mask;
    dtspwm_pkg::dtspwm_step_t r;
    mask = 8'hff >> (3'h7 - psc);
    r.low = low;
    r.high = high;
    r.high_wrap = 1'b0;
    r.ovf = 1'b0;
    if (tick) begin
      case (mode)
        dtspwm_pkg::MODE_VAR: begin
          // upper low-byte bits beyond the prescaler keep their value
          r.low = (low & ~mask) | (8'(low + 8'h01) & mask);
          if ((low & mask) == mask) begin
            r.high = 8'(high + 8'h01);
            r.high_wrap = (high == 8'hff);
            r.ovf = (high == 8'hff);
          end
        end
        dtspwm_pkg::MODE_AR16: begin
          r.low = 8'(low + 8'h01);
          if (low == 8'hff) begin
            if (pwm) begin
              r.low = rl;
              r.high = 8'(high + 8'h01);
              r.high_wrap = (high == 8'hff);
              r.ovf = (high == 8'hff);
            end else if (high == 8'hff) begin
              r.low = rl;
              r.high = rh;
              r.high_wrap = 1'b1;
              r.ovf = 1'b1;
            end else begin
              r.high = 8'(high + 8'h01);
            end
          end
        end
        dtspwm_pkg::MODE_AR8: begin
          r.low = (low == 8'hff) ? high : 8'(low + 8'h01);
          r.ovf = (low == 8'hff);
        end
        default: begin
          r.low = 8'(low + 8'h01);
          r.ovf = (low == 8'hff);
        end
      endcase
    end
    return r;
  endfunction

  // pwm output: low at compare or with compare 00, high at count 00
  function automatic logic pwm_next(
    input logic [7:0] high,
    input logic [7:0] cmp,
    input logic cur
  );
    logic r;
    r = cur;
    if (cmp == 8'h00) begin
      r = 1'b0;
    end else if (high == cmp) begin
      r = 1'b0;
    end else if (high == 8'h00) begin
      r = 1'b1;
    end
    return r;
  endfunction

  dtspwm_pinsync u_pinsync (
    .clk_i(clk_i),
    .resetn_i(resetn_i),
    .pin_i({ext_irq_pin_b_i, ext_irq_pin_a_i, timer_pin_b_i, timer_pin_a_i}),
    .level_o(pin_level),
    .fall_o(pin_fall)
  );

  assign ctrl_wr = wr_i && (addr_i == dtspwm_pkg::OFS_CTRL_FLAGS);

  dtspwm_extirq u_extirq (
    .clk_i(clk_i),
    .resetn_i(resetn_i),
    .type_i({st_ff.ext_irq_type_b, st_ff.ext_irq_type_a}),
    .level_i({pin_level[dtspwm_pkg::PIN_EIRQ_B], pin_level[dtspwm_pkg::PIN_EIRQ_A]}),
    .fall_i({pin_fall[dtspwm_pkg::PIN_EIRQ_B], pin_fall[dtspwm_pkg::PIN_EIRQ_A]}),
    .ack_i({vector_ack_eirq_b_i, vector_ack_eirq_a_i}),
    .wr_i(ctrl_wr),
    .wdata_i({wdata_i[dtspwm_pkg::BIT_EIRQ_FLAG_B], wdata_i[dtspwm_pkg::BIT_EIRQ_FLAG_A]}),
    .flag_o(eirq_flag)
  );

  // mode decode and pwm qualification
  assign mode_a = st_ff.mode_sel[dtspwm_pkg::NIB_A + dtspwm_pkg::POS_MODE +: 2];
  assign mode_b = st_ff.mode_sel[dtspwm_pkg::NIB_B + dtspwm_pkg::POS_MODE +: 2];
  assign split = (mode_a == dtspwm_pkg::MODE_SPLIT);
  assign pwm_act_a = st_ff.prescale_pwm[dtspwm_pkg::BIT_PWM_EN_A] && !mode_a[1];
  assign pwm_act_b = st_ff.prescale_pwm[dtspwm_pkg::BIT_PWM_EN_B] && !mode_b[1];

  // count enables: run bit, optional gating on the irq pin, clock or pin edge
  assign tick_a = st_ff.run_bit_a
    && (!st_ff.mode_sel[dtspwm_pkg::NIB_A + dtspwm_pkg::POS_GATE] || pin_level[dtspwm_pkg::PIN_EIRQ_A])
    && (st_ff.mode_sel[dtspwm_pkg::NIB_A + dtspwm_pkg::POS_CNT_SEL]
        ? pin_fall[dtspwm_pkg::PIN_TMR_A] : 1'b1);
  // in split mode timer b's run bit belongs to timer a's high byte
  assign run_eff_b = split ? 1'b1 : st_ff.run_bit_b;
  assign tick_b = run_eff_b && (mode_b != dtspwm_pkg::MODE_SPLIT)
    && (!st_ff.mode_sel[dtspwm_pkg::NIB_B + dtspwm_pkg::POS_GATE] || pin_level[dtspwm_pkg::PIN_EIRQ_B])
    && (st_ff.mode_sel[dtspwm_pkg::NIB_B + dtspwm_pkg::POS_CNT_SEL]
        ? pin_fall[dtspwm_pkg::PIN_TMR_B] : 1'b1);
  assign tick_split_high = split && st_ff.run_bit_b;

  assign step_a = timer_step(mode_a, st_ff.prescale_pwm[dtspwm_pkg::POS_PSC_A +: 3], pwm_act_a, tick_a,
    st_ff.low_count_a, st_ff.high_count_a, st_ff.low_reload_a, st_ff.high_reload_a);
  assign step_b = timer_step(mode_b, st_ff.prescale_pwm[dtspwm_pkg::POS_PSC_B +: 3], pwm_act_b, tick_b,
    st_ff.low_count_b, st_ff.high_count_b, st_ff.low_reload_b, st_ff.high_reload_b);

  // next state: counting first, then register writes override the counters,
  // then hardware flag sets override any clear in the same cycle
  always_comb begin
    nxt_st = st_ff;
    // counters
    nxt_st.low_count_a = step_a.low;
    nxt_st.high_count_a = split ? (tick_split_high ? 8'(st_ff.high_count_a + 8'h01) : st_ff.high_count_a)
                                : step_a.high;
    nxt_st.low_count_b = step_b.low;
    nxt_st.high_count_b = step_b.high;
    // baud tick keeps flowing in split mode without touching the flag
    nxt_st.baud_b = step_b.ovf;
    // compare copies follow the reload byte every cycle while pwm is off, only on a high byte wrap while it is on
    if (!pwm_act_a || step_a.high_wrap) begin
      nxt_st.cmp_a = st_ff.high_reload_a;
    end
    if (!pwm_act_b || step_b.high_wrap) begin
      nxt_st.cmp_b = st_ff.high_reload_b;
    end
    nxt_st.pwm_a = pwm_act_a ? pwm_next(st_ff.high_count_a, st_ff.cmp_a, st_ff.pwm_a) : 1'b0;
    nxt_st.pwm_b = pwm_act_b ? pwm_next(st_ff.high_count_b, st_ff.cmp_b, st_ff.pwm_b) : 1'b0;
    // flag clear on vector entry
    if (vector_ack_ovf_a_i) begin
      nxt_st.overflow_flag_a = 1'b0;
    end
    if (vector_ack_ovf_b_i) begin
      nxt_st.overflow_flag_b = 1'b0;
    end
    // register writes
    if (wr_i) begin
      case (addr_i)
        dtspwm_pkg::OFS_CTRL_FLAGS: begin
          nxt_st.overflow_flag_b = wdata_i[dtspwm_pkg::BIT_OVF_B];
          nxt_st.run_bit_b = wdata_i[dtspwm_pkg::BIT_RUN_B];
          nxt_st.overflow_flag_a = wdata_i[dtspwm_pkg::BIT_OVF_A];
          nxt_st.run_bit_a = wdata_i[dtspwm_pkg::BIT_RUN_A];
          nxt_st.ext_irq_type_b = wdata_i[dtspwm_pkg::BIT_EIRQ_TYPE_B];
          nxt_st.ext_irq_type_a = wdata_i[dtspwm_pkg::BIT_EIRQ_TYPE_A];
        end
        dtspwm_pkg::OFS_MODE_SEL: nxt_st.mode_sel = wdata_i;
        dtspwm_pkg::OFS_A_COUNT_LOW: nxt_st.low_count_a = wdata_i;
        dtspwm_pkg::OFS_B_COUNT_LOW: nxt_st.low_count_b = wdata_i;
        dtspwm_pkg::OFS_A_COUNT_HIGH: nxt_st.high_count_a = wdata_i;
        dtspwm_pkg::OFS_B_COUNT_HIGH: nxt_st.high_count_b = wdata_i;
        dtspwm_pkg::OFS_PRESCALE_PWM: nxt_st.prescale_pwm = wdata_i;
        dtspwm_pkg::OFS_A_RELOAD_LOW: nxt_st.low_reload_a = wdata_i;
        dtspwm_pkg::OFS_B_RELOAD_LOW: nxt_st.low_reload_b = wdata_i;
        dtspwm_pkg::OFS_A_RELOAD_HIGH: nxt_st.high_reload_a = wdata_i;
        dtspwm_pkg::OFS_B_RELOAD_HIGH: nxt_st.high_reload_b = wdata_i;
        default: begin
          // unmapped writes are dropped
        end
      endcase
    end
    // hardware sets win over software or vector clears
    if (step_a.ovf) begin
      nxt_st.overflow_flag_a = 1'b1;
    end
    if (split ? (tick_split_high && st_ff.high_count_a == 8'hff) : step_b.ovf) begin
      nxt_st.overflow_flag_b = 1'b1;
    end
    // read data stands only in the cycle after the read strobe
    nxt_st.rdata = 8'h00;
    if (rd_i) begin
      case (addr_i)
        dtspwm_pkg::OFS_CTRL_FLAGS: nxt_st.rdata = {st_ff.overflow_flag_b, st_ff.run_bit_b,
          st_ff.overflow_flag_a, st_ff.run_bit_a, eirq_flag[1], st_ff.ext_irq_type_b,
          eirq_flag[0], st_ff.ext_irq_type_a};
        dtspwm_pkg::OFS_MODE_SEL: nxt_st.rdata = st_ff.mode_sel;
        dtspwm_pkg::OFS_A_COUNT_LOW: nxt_st.rdata = st_ff.low_count_a;
        dtspwm_pkg::OFS_B_COUNT_LOW: nxt_st.rdata = st_ff.low_count_b;
        dtspwm_pkg::OFS_A_COUNT_HIGH: nxt_st.rdata = st_ff.high_count_a;
        dtspwm_pkg::OFS_B_COUNT_HIGH: nxt_st.rdata = st_ff.high_count_b;
        dtspwm_pkg::OFS_PRESCALE_PWM: nxt_st.rdata = st_ff.prescale_pwm;
        dtspwm_pkg::OFS_A_RELOAD_LOW: nxt_st.rdata = st_ff.low_reload_a;
        dtspwm_pkg::OFS_B_RELOAD_LOW: nxt_st.rdata = st_ff.low_reload_b;
        dtspwm_pkg::OFS_A_RELOAD_HIGH: nxt_st.rdata = st_ff.high_reload_a;
        dtspwm_pkg::OFS_B_RELOAD_HIGH: nxt_st.rdata = st_ff.high_reload_b;
        default: nxt_st.rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      st_ff <= '0;
      st_ff.mode_sel <= dtspwm_pkg::RST_MODE_SEL;
      st_ff.prescale_pwm <= dtspwm_pkg::RST_PRESCALE_PWM;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign rdata_o = st_ff.rdata;
  assign overflow_flag_a_o = st_ff.overflow_flag_a;
  assign overflow_flag_b_o = st_ff.overflow_flag_b;
  assign ext_irq_flag_a_o = eirq_flag[0];
  assign ext_irq_flag_b_o = eirq_flag[1];
  assign baud_tick_b_o = st_ff.baud_b;
  // pins are driven only while pwm is active; otherwise they stay inputs
  assign timer_pin_a_o = st_ff.pwm_a;
  assign timer_pin_a_oe_o = pwm_act_a;
  assign timer_pin_b_o = st_ff.pwm_b;
  assign timer_pin_b_oe_o = pwm_act_b;

endmodule

// ===== testbench/dtspwm_chk.sv
// Purpose: port-level assertions for the dual timer block
// Assumes: only software writes mode, type and pwm bits
// Notes: bound to dtspwm_top after the module
module dtspwm_chk (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [7:0] rdata_o,
  input wire logic ext_irq_pin_a_i,
  input wire logic vector_ack_eirq_a_i,
  input wire logic vector_ack_ovf_b_i,
  input wire logic overflow_flag_b_o,
  input wire logic ext_irq_flag_a_o,
  input wire logic baud_tick_b_o,
  input wire logic timer_pin_a_o,
  input wire logic timer_pin_a_oe_o,
  input wire logic timer_pin_b_o,
  input wire logic timer_pin_b_oe_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mode_ff, psc_ff;
  logic type_a_ff, split_a, frz_b;
  // shadows follow the block's registers
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      mode_ff <= 8'h00;
      psc_ff <= 8'h24;
      type_a_ff <= 1'b0;
    end else if (wr_i) begin
      if (addr_i == 8'h89) mode_ff <= wdata_i;
      if (addr_i == 8'h91) psc_ff <= wdata_i;
      if (addr_i == 8'h88) type_a_ff <= wdata_i[0];
    end
  end
  // in split, flag b belongs to a's high byte
  assign split_a = (mode_ff[1:0] == 2'h3);
  assign frz_b = (mode_ff[5:4] == 2'h3);
  default clocking dck @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  a_rdata_idle: assert property (!$past(rd_i) |-> rdata_o == 8'h00)
    else $error("read data outside the read slot");
  a_oe_pwm_a: assert property (timer_pin_a_oe_o == (psc_ff[6] && !mode_ff[1]))
    else $error("pin a enable mismatch");
  a_oe_pwm_b: assert property (timer_pin_b_oe_o == (psc_ff[7] && !mode_ff[5]))
    else $error("pin b enable mismatch");
  a_out_off_a: assert property (!timer_pin_a_oe_o && !$past(timer_pin_a_oe_o) |-> !timer_pin_a_o)
    else $error("pin a driven while pwm off");
  a_out_off_b: assert property (!timer_pin_b_oe_o && !$past(timer_pin_b_oe_o) |-> !timer_pin_b_o)
    else $error("pin b driven while pwm off");
  a_level_low_a: assert property ((!type_a_ff && !ext_irq_pin_a_i) [*5] |-> ext_irq_flag_a_o)
    else $error("level flag a not set");
  a_level_high_a: assert property ((!type_a_ff && ext_irq_pin_a_i) [*5] |-> !ext_irq_flag_a_o)
    else $error("level flag a not clear");
  a_edge_ack_a: assert property ((type_a_ff && ext_irq_pin_a_i) [*5] ##0 vector_ack_eirq_a_i |=> !ext_irq_flag_a_o)
    else $error("edge flag a survives ack");
  a_wrap_flag_b: assert property (!$past(split_a) && baud_tick_b_o |-> overflow_flag_b_o)
    else $error("flag b late on overflow");
  a_ack_clr_b: assert property (vector_ack_ovf_b_i && !split_a ##1 !baud_tick_b_o |-> !overflow_flag_b_o)
    else $error("flag b survives ack");
  a_freeze_b: assert property (frz_b && $past(frz_b) |-> !baud_tick_b_o)
    else $error("timer b counts in mode 3");
  c_flag_b: cover property ($rose(overflow_flag_b_o));
  c_pwm_a: cover property ($rose(timer_pin_a_o));
  c_edge_a: cover property ($rose(ext_irq_flag_a_o) && type_a_ff);
endmodule

bind dtspwm_top dtspwm_chk chk_u (.*);

// ===== testbench/dtspwm_cpu_model.sv
// Purpose: cpu side of the register port and of the vector acknowledges
// Assumes: one access per task call, strobes one cycle long
// Notes: a released address or data bus shows the inverse of its last value
module dtspwm_cpu_model (
  input wire logic clk_i,
  input wire logic [7:0] rdata_i,
  output logic [7:0] addr_o,
  output logic [7:0] wdata_o,
  output logic wr_o,
  output logic rd_o,
  output logic [3:0] ack_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // idle bus at time zero
  initial begin
    {addr_o, wdata_o, wr_o, rd_o, ack_o} = '0;
  end
  // run bits are software-owned, so starting and stopping comes through here
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    addr_o <= a;
    wdata_o <= d;
    wr_o <= 1'b1;
    @(posedge clk_i);
    wr_o <= 1'b0;
    addr_o <= ~a;
    wdata_o <= ~d;
  endtask
  // read data stand only in the cycle after the strobe; taken once settled, not at an edge
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_i);
    addr_o <= a;
    rd_o <= 1'b1;
    @(posedge clk_i);
    rd_o <= 1'b0;
    addr_o <= ~a;
    #1 d = rdata_i;
  endtask
  // vectoring to a handler is one pulse on its acknowledge
  task automatic ack(input int i);
    @(posedge clk_i);
    ack_o[i] <= 1'b1;
    @(posedge clk_i);
    ack_o <= 4'h0;
  endtask
endmodule

// ===== testbench/tb.sv
// Purpose: self-checking bench for the dual timer block
// Assumes: 25 MHz clock, cpu model drives the register port
// Notes: random data from an xorshift seeded with a fixed value
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i;
  logic resetn_i;
  logic [7:0] addr, wdata, rdata;
  logic wr, rd;
  logic [3:0] ack;
  logic [3:0] pin;
  wire [3:0] flags;
  wire [1:0] po, poe, tpin;
  logic baud;
  int bad_count, comparisons, n;
  logic [31:0] seed;
  logic [7:0] v, got, g2, e;

  // timer pins are shared: the block's pwm driver wins while enabled
  assign tpin = (poe & po) | (~poe & pin[1:0]);

  dtspwm_cpu_model cpu_u (.clk_i(clk_i), .rdata_i(rdata), .addr_o(addr), .wdata_o(wdata), .wr_o(wr),
    .rd_o(rd), .ack_o(ack));
  dtspwm_top dut_u (.clk_i(clk_i), .resetn_i(resetn_i), .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd),
    .rdata_o(rdata), .timer_pin_a_i(tpin[0]), .timer_pin_b_i(tpin[1]), .ext_irq_pin_a_i(pin[2]),
    .ext_irq_pin_b_i(pin[3]), .vector_ack_ovf_a_i(ack[0]), .vector_ack_ovf_b_i(ack[1]),
    .vector_ack_eirq_a_i(ack[2]), .vector_ack_eirq_b_i(ack[3]), .overflow_flag_a_o(flags[0]),
    .overflow_flag_b_o(flags[1]), .ext_irq_flag_a_o(flags[2]), .ext_irq_flag_b_o(flags[3]),
    .baud_tick_b_o(baud), .timer_pin_a_o(po[0]), .timer_pin_a_oe_o(poe[0]), .timer_pin_b_o(po[1]),
    .timer_pin_b_oe_o(poe[1]));

  // 40 ns period
  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  // high byte of mode 0 after cyc counting cycles with field p
  function automatic int m0_high(input int cyc, input int p);
    return cyc >> (p + 1);
  endfunction
  task automatic rnd(output logic [7:0] r);
    seed = xs(seed);
    r = seed[7:0];
  endtask
  task automatic chk(input logic [7:0] g, input logic [7:0] w);
    comparisons++;
    if (g !== w) begin
      bad_count++;
      $display("Error at %0t: got %h expected %h", $time, g, w);
    end
  endtask
  task automatic results();
    if (bad_count == 0 && comparisons > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // bounded wait; a run-out counts as a mismatch and ends the run
  task automatic wait_flag(input int i, input logic val);
    n = 0;
    while (flags[i] !== val && n < 300) begin
      @(posedge clk_i);
      n++;
    end
    chk({7'h0, flags[i]}, {7'h0, val});
    if (n >= 300) results();
  endtask

  initial begin
    resetn_i = 1'b0;
    pin = 4'hf;
    seed = 32'hf951;
    bad_count = 0;
    comparisons = 0;
    repeat (5) @(posedge clk_i);
    resetn_i <= 1'b1;
    // reset values everywhere, 0x90 is unmapped
    for (int a = 8'h88; a <= 8'h95; a++) begin
      cpu_u.rd_reg(a[7:0], got);
      chk(got, (a == 8'h91) ? 8'h24 : 8'h00);
    end
    // byte registers hold what was written while stopped
    for (int a = 8'h8a; a <= 8'h95; a++) begin
      rnd(v);
      cpu_u.wr_reg(a[7:0], v);
      cpu_u.rd_reg(a[7:0], got);
      chk(got, (a > 8'h8d && a < 8'h91) ? 8'h00 : v);
    end
    cpu_u.wr_reg(8'h91, 8'h24);
    // mode 1 timer a: 16-bit wrap reloads the high byte
    cpu_u.wr_reg(8'h89, 8'h01);
    rnd(v);
    cpu_u.wr_reg(8'h94, v);
    cpu_u.wr_reg(8'h92, 8'h00);
    cpu_u.wr_reg(8'h8c, 8'hff);
    cpu_u.wr_reg(8'h8a, 8'hf0);
    cpu_u.wr_reg(8'h88, 8'h10);
    wait_flag(0, 1'b1);
    cpu_u.wr_reg(8'h88, 8'h20);
    cpu_u.rd_reg(8'h8c, got);
    chk(got, v);
    cpu_u.ack(0);
    wait_flag(0, 1'b0);
    // mode 2 timer b: low reloads from the untouched high byte
    cpu_u.wr_reg(8'h89, 8'h20);
    cpu_u.wr_reg(8'h8d, 8'hfe);
    cpu_u.wr_reg(8'h8b, 8'hfd);
    cpu_u.wr_reg(8'h88, 8'h40);
    wait_flag(1, 1'b1);
    cpu_u.wr_reg(8'h88, 8'h80);
    cpu_u.rd_reg(8'h8d, got);
    chk(got, 8'hfe);
    cpu_u.rd_reg(8'h8b, got);
    chk({1'b0, got[7:1]}, 8'h7f);
    cpu_u.ack(1);
    wait_flag(1, 1'b0);
    // split: a low and a high each raise their own flag, b runs then freezes
    cpu_u.wr_reg(8'h8c, 8'hf0);
    cpu_u.wr_reg(8'h8a, 8'hf8);
    cpu_u.wr_reg(8'h89, 8'h03);
    cpu_u.wr_reg(8'h88, 8'h50);
    wait_flag(0, 1'b1);
    wait_flag(1, 1'b1);
    cpu_u.rd_reg(8'h8b, got);
    cpu_u.rd_reg(8'h8b, g2);
    chk({7'h0, got != g2}, 8'h01);
    cpu_u.wr_reg(8'h89, 8'h33);
    cpu_u.rd_reg(8'h8b, got);
    cpu_u.rd_reg(8'h8b, g2);
    chk(g2, got);
    cpu_u.wr_reg(8'h88, 8'ha0);
    cpu_u.wr_reg(8'h89, 8'h00);
    cpu_u.ack(0);
    cpu_u.ack(1);
    // counter function: count falling edges of timer pin a
    cpu_u.wr_reg(8'h89, 8'h06);
    cpu_u.wr_reg(8'h8c, 8'h00);
    cpu_u.wr_reg(8'h8a, 8'h00);
    cpu_u.wr_reg(8'h88, 8'h10);
    rnd(v);
    for (int k = 0; k <= int'(v[3:0]); k++) begin
      pin[0] <= 1'b0;
      repeat (3) @(posedge clk_i);
      pin[0] <= 1'b1;
      repeat (3) @(posedge clk_i);
    end
    cpu_u.wr_reg(8'h88, 8'h00);
    cpu_u.rd_reg(8'h8a, got);
    chk(got, {4'h0, v[3:0]} + 8'h01);
    // gate: interrupt pin low stops the count, high lets it run
    cpu_u.wr_reg(8'h89, 8'h0a);
    cpu_u.wr_reg(8'h8a, 8'h00);
    pin[2] <= 1'b0;
    cpu_u.wr_reg(8'h88, 8'h10);
    repeat (20) @(posedge clk_i);
    cpu_u.rd_reg(8'h8a, got);
    chk(got, 8'h00);
    pin[2] <= 1'b1;
    repeat (20) @(posedge clk_i);
    cpu_u.rd_reg(8'h8a, got);
    chk({7'h0, got == 8'h00}, 8'h00);
    cpu_u.wr_reg(8'h88, 8'h00);
    // external interrupts: edge type then level type on both pins
    for (int i = 0; i < 2; i++) begin
      cpu_u.wr_reg(8'h88, 8'h01 << (2 * i));
      pin[2 + i] <= 1'b0;
      wait_flag(2 + i, 1'b1);
      pin[2 + i] <= 1'b1;
      repeat (6) @(posedge clk_i);
      cpu_u.ack(2 + i);
      wait_flag(2 + i, 1'b0);
      cpu_u.wr_reg(8'h88, 8'h00);
      pin[2 + i] <= 1'b0;
      wait_flag(2 + i, 1'b1);
      pin[2 + i] <= 1'b1;
      wait_flag(2 + i, 1'b0);
    end
    // pwm mode 1 per timer: high time per 256-cycle period equals compare
    for (int i = 0; i < 2; i++) begin
      rnd(v);
      if (v == 8'h00) v = 8'h01;
      cpu_u.wr_reg(8'h92 + i[7:0], 8'hff);
      cpu_u.wr_reg(8'h94 + i[7:0], v);
      cpu_u.wr_reg(8'h89, 8'h01 << (4 * i));
      cpu_u.wr_reg(8'h91, 8'h24 | (8'h40 << i));
      cpu_u.wr_reg(8'h88, 8'h10 << (2 * i));
      for (int c = 0; c < 2; c++) begin
        repeat (600) @(posedge clk_i);
        n = 0;
        repeat (256) begin
          @(posedge clk_i);
          n += int'(po[i]);
        end
        chk(n[7:0], v);
        v = 8'h00;
        cpu_u.wr_reg(8'h94 + i[7:0], v);
      end
      cpu_u.wr_reg(8'h89, 8'h22);
      cpu_u.wr_reg(8'h88, 8'h00);
    end
    // mode 0 for every prescale code of timer a
    cpu_u.wr_reg(8'h89, 8'h00);
    for (int p = 0; p < 8; p++) begin
      cpu_u.wr_reg(8'h91, p[7:0]);
      cpu_u.wr_reg(8'h8a, 8'h00);
      cpu_u.wr_reg(8'h8c, 8'h00);
      cpu_u.wr_reg(8'h88, 8'h10);
      repeat (20 << (p + 1)) @(posedge clk_i);
      cpu_u.wr_reg(8'h88, 8'h00);
      cpu_u.rd_reg(8'h8c, got);
      e = 8'(m0_high(20 << (p + 1), p));
      chk({7'h0, (got - e) < 8'h02}, 8'h01);
    end
    results();
  end
endmodule
